// ### rtl/selftest_if.sv
// Carrier between the main block and its self-test sequencer.
// Assumes both ends share sys_clk.
`timescale 1ns/100ps
interface selftest_if;
	logic start;
	logic extended;
	logic busy;
	logic done;
	logic [7:0] result;

	modport master (output start, output extended, input busy, input done, input result);
	modport slave (input start, input extended, output busy, output done, output result);
endinterface

// ### rtl/selftest_seq.sv
// Self-test sequencer: steps through every subtest and collects failure bits.
// Assumes each subtest answers with a done pulse and a fail level.
`timescale 1ns/100ps
module selftest_seq
	import status_trigger_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Carrier to the main block.
	selftest_if.slave st,
	// Subtest engines.
	output logic [7:0] subtest_start,
	input wire logic subtest_done,
	input wire logic subtest_fail
);

	typedef enum logic [1:0] {
		S_IDLE,
		S_LAUNCH,
		S_WAIT,
		S_DONE
	} seq_state_e;

	seq_state_e state;
	logic [2:0] index;
	logic [7:0] fails;
	logic [7:0] active_mask;
	logic done_q;

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	// Subtests not in the active mask are skipped, so the plain query never runs the output tests.
	wire logic index_active = active_mask[index];
	wire logic last_index = (index == 3'h7);
	wire logic [7:0] index_onehot = 8'h01 << index;

	assign subtest_start = (state == S_LAUNCH && index_active) ? index_onehot : 8'h00;
	assign st.busy = (state != S_IDLE);
	assign st.done = done_q;
	assign st.result = fails & active_mask;

	// A failing subtest sets its own bit and the walk carries on regardless.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= S_IDLE;
			index <= 3'h0;
			fails <= 8'h00;
			active_mask <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state)
				S_IDLE: begin
					if (st.start) begin
						active_mask <= st.extended ? TST_DIAG_MASK : TST_PLAIN_MASK;
						fails <= 8'h00;
						index <= 3'h0;
						state <= S_LAUNCH;
					end
				end
				S_LAUNCH: begin
					if (index_active) begin
						state <= S_WAIT;
					end else if (last_index) begin
						state <= S_DONE;
					end else begin
						index <= index + 3'h1;
					end
				end
				S_WAIT: begin
					if (subtest_done) begin
						fails <= fails | (subtest_fail ? index_onehot : 8'h00);
						state <= last_index ? S_DONE : S_LAUNCH;
						index <= last_index ? index : index + 3'h1;
					end
				end
				S_DONE: begin
					done_q <= 1'b1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// ### rtl/status_trigger_core.sv
// Status byte, service request, bus trigger, self test and wait-to-continue logic.
// Assumes an internal command decoder presenting one-cycle command strobes with data.
`timescale 1ns/100ps
module status_trigger_core
	import status_trigger_pkg::*;
#(
	parameter int LEVEL_W = 16
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic resetn,
	// Command strobes from the decoder.
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_mask_write,
	input wire logic [7:0] cmd_mask_data,
	input wire logic cmd_mask_query,
	input wire logic cmd_status_query,
	input wire logic cmd_serial_poll,
	input wire logic cmd_trigger,
	input wire logic cmd_group_trigger,
	input wire logic cmd_init_arm,
	input wire logic cmd_abort,
	input wire logic cmd_tst_query,
	input wire logic cmd_diag_query,
	input wire logic cmd_wait,
	// Trigger configuration.
	input wire logic continuous_arm,
	input wire trig_src_e trigger_source,
	input wire logic listen_addressed,
	input wire logic output_on,
	input wire logic [LEVEL_W-1:0] trig_volt_level,
	input wire logic [LEVEL_W-1:0] trig_curr_level,
	// Status sources.
	input wire logic operation_summary,
	input wire logic event_summary,
	input wire logic output_queue_count_nonzero,
	input wire logic questionable_summary,
	input wire logic error_queue_nonempty,
	input wire logic sequence_running,
	input wire logic busy,
	input wire logic ops_pending,
	// Responses.
	output logic resp_valid,
	output logic [7:0] resp_data,
	output logic service_request,
	output logic [7:0] service_request_mask,
	output logic [7:0] summary_status_byte,
	// Trigger result.
	output logic waiting_for_trigger,
	output logic trigger_fire,
	output logic [LEVEL_W-1:0] applied_volt_level,
	output logic [LEVEL_W-1:0] applied_curr_level,
	// Self-test engines.
	output logic [7:0] subtest_start,
	input wire logic subtest_done,
	input wire logic subtest_fail
);

	selftest_if st();

	logic [7:0] request_mask;
	logic rqs;
	logic wait_hold;
	logic tst_pending;
	logic [7:0] next_resp;
	logic next_resp_valid;

	// ----------------------------------------------------------------
	// Status byte assembly
	// ----------------------------------------------------------------
	// The byte is a live view of its sources, so it only reads zero once every cause is gone.
	wire logic [7:0] status_raw = {operation_summary, 1'b0, event_summary, output_queue_count_nonzero,
		questionable_summary, error_queue_nonempty, sequence_running, busy};
	wire logic mss = |(status_raw & request_mask);
	wire logic [7:0] status_with_summary = status_raw | ({7'h00, mss} << STATUS_SUMMARY_BIT);
	wire logic [7:0] status_with_request = status_raw | ({7'h00, rqs} << STATUS_SUMMARY_BIT);

	assign summary_status_byte = status_with_summary;
	assign service_request_mask = request_mask;
	assign service_request = rqs;

	// ----------------------------------------------------------------
	// Trigger qualification
	// ----------------------------------------------------------------
	wire logic any_trigger = cmd_valid && (cmd_trigger || cmd_group_trigger);
	wire logic trigger_accepted = any_trigger && listen_addressed && output_on;
	// An unarmed trigger simply falls through here and raises no error.
	wire logic trigger_go = trigger_accepted && (trigger_source == TRIG_SRC_BUS) && waiting_for_trigger;

	// ----------------------------------------------------------------
	// Command flow control
	// ----------------------------------------------------------------
	// While held, the decoder sees ready low; serial polls are bus-level and never stall.
	assign cmd_ready = !wait_hold && !tst_pending && !st.busy;
	wire logic wait_release = wait_hold && !ops_pending && !busy;
	assign st.start = cmd_valid && cmd_ready && (cmd_tst_query || cmd_diag_query);
	assign st.extended = cmd_diag_query;

	// Service-request mask; bit 6 is never stored and so always reads back zero.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			request_mask <= MASK_RESET;
		end else if (cmd_valid && cmd_ready && cmd_mask_write) begin
			request_mask <= cmd_mask_data & MASK_WRITABLE;
		end
	end

	// Request flag: a new summary rise sets it, a serial poll clears it, the set wins.
	logic mss_q;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rqs <= 1'b0;
			mss_q <= 1'b0;
		end else begin
			mss_q <= mss;
			if (mss && !mss_q) begin
				rqs <= 1'b1;
			end else if (cmd_serial_poll) begin
				rqs <= 1'b0;
			end
		end
	end

	// Arming: continuous rearm after each fire, single arm consumed by one fire.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			waiting_for_trigger <= 1'b0;
		end else if (cmd_valid && cmd_abort) begin
			waiting_for_trigger <= 1'b0;
		end else if (trigger_go) begin
			waiting_for_trigger <= continuous_arm;
		end else if ((cmd_valid && cmd_init_arm) || continuous_arm) begin
			waiting_for_trigger <= 1'b1;
		end
	end

	// Output levels move to the stored triggered values on each fire.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			trigger_fire <= 1'b0;
			applied_volt_level <= '0;
			applied_curr_level <= '0;
		end else begin
			trigger_fire <= trigger_go;
			if (trigger_go) begin
				applied_volt_level <= trig_volt_level;
				applied_curr_level <= trig_curr_level;
			end
		end
	end

	// Wait-to-continue holds the command port until nothing is pending and the busy source is low.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wait_hold <= 1'b0;
		end else if (cmd_valid && cmd_ready && cmd_wait) begin
			wait_hold <= 1'b1;
		end else if (wait_release) begin
			wait_hold <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Response selection
	// ----------------------------------------------------------------
	always_comb begin
		next_resp = 8'h00;
		next_resp_valid = 1'b0;
		if (st.done) begin
			next_resp = st.result;
			next_resp_valid = 1'b1;
		end else if (cmd_serial_poll) begin
			next_resp = status_with_request;
			next_resp_valid = 1'b1;
		end else if (cmd_valid && cmd_ready && cmd_status_query) begin
			next_resp = status_with_summary;
			next_resp_valid = 1'b1;
		end else if (cmd_valid && cmd_ready && cmd_mask_query) begin
			next_resp = request_mask;
			next_resp_valid = 1'b1;
		end
	end

	// Responses are registered; a test pending flag keeps ready low through the done cycle.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			resp_valid <= 1'b0;
			resp_data <= 8'h00;
			tst_pending <= 1'b0;
		end else begin
			resp_valid <= next_resp_valid;
			resp_data <= next_resp;
			if (st.start) begin
				tst_pending <= 1'b1;
			end else if (st.done) begin
				tst_pending <= 1'b0;
			end
		end
	end

	// Self-test walker; it runs every selected subtest regardless of failures.
	selftest_seq u_selftest (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.st(st.slave),
		.subtest_start(subtest_start),
		.subtest_done(subtest_done),
		.subtest_fail(subtest_fail)
	);

endmodule

// ### rtl/status_trigger_pkg.sv
// Package for the status, trigger and common-command block.
// Assumes a single clock domain and a command decoder that emits one-cycle strobes.
package status_trigger_pkg;

	// ----------------------------------------------------------------
	// Status byte layout
	// ----------------------------------------------------------------
	localparam int STATUS_OPERATION_BIT = 7;
	localparam int STATUS_SUMMARY_BIT = 6;
	localparam int STATUS_EVENT_BIT = 5;
	localparam int STATUS_MESSAGE_BIT = 4;
	localparam int STATUS_QUESTIONABLE_BIT = 3;
	localparam int STATUS_ERROR_BIT = 2;
	localparam int STATUS_RUN_BIT = 1;
	localparam int STATUS_BUSY_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] MASK_WRITABLE = 8'hbf;
	localparam logic [7:0] TST_PLAIN_MASK = 8'h17;
	localparam logic [7:0] TST_DIAG_MASK = 8'hf7;

	// ----------------------------------------------------------------
	// Self-test result bit positions
	// ----------------------------------------------------------------
	localparam int TST_ROM_BIT = 0;
	localparam int TST_RAM_BIT = 1;
	localparam int TST_FLASH_BIT = 2;
	localparam int TST_ALINK_BIT = 4;
	localparam int TST_LOOP_BIT = 5;
	localparam int TST_VMAX_BIT = 6;
	localparam int TST_VMIN_BIT = 7;
	localparam int TST_COUNT = 8;

	// Trigger source selection.
	typedef enum logic [1:0] {
		TRIG_SRC_IMM,
		TRIG_SRC_BUS,
		TRIG_SRC_EXT
	} trig_src_e;

endpackage

// ### verification/status_trigger_checker.sv
// Checker for the status and trigger core, watching only its ports.
// Assumes one clock with a synchronous active-low reset; bound below.
`timescale 1ns/100ps
module status_trigger_checker
	import status_trigger_pkg::*;
#(
	parameter int LEVEL_W = 16
) (
	// Clock, reset and command strobes.
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_mask_query,
	input wire logic cmd_status_query,
	input wire logic cmd_serial_poll,
	input wire logic cmd_trigger,
	input wire logic cmd_group_trigger,
	input wire logic cmd_wait,
	// Trigger gating.
	input wire logic continuous_arm,
	input wire trig_src_e trigger_source,
	input wire logic listen_addressed,
	input wire logic output_on,
	input wire logic [LEVEL_W-1:0] trig_volt_level,
	// Results.
	input wire logic resp_valid,
	input wire logic [7:0] resp_data,
	input wire logic service_request,
	input wire logic [7:0] service_request_mask,
	input wire logic [7:0] summary_status_byte,
	input wire logic waiting_for_trigger,
	input wire logic trigger_fire,
	input wire logic [LEVEL_W-1:0] applied_volt_level
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// A taken command, and a trigger that passes every gate.
	wire taken = cmd_valid && cmd_ready;
	wire fire_ok = cmd_valid && (cmd_trigger || cmd_group_trigger) && listen_addressed && output_on &&
		trigger_source == TRIG_SRC_BUS && waiting_for_trigger;
	wire mss = summary_status_byte[6];
	summary_or_a: assert property (mss == |(summary_status_byte & service_request_mask & 8'hbf))
		else $error("Summary bit disagrees with enabled status bits.");
	request_set_a: assert property ($rose(mss) |=> service_request)
		else $error("Request flag missed a summary rise.");
	poll_clear_a: assert property (cmd_serial_poll && !$rose(mss) |=> !service_request)
		else $error("Serial poll left the request flag set.");
	poll_answer_a: assert property (cmd_serial_poll |=> resp_valid && resp_data[6] == $past(service_request))
		else $error("Serial poll answer lacks the request flag.");
	status_answer_a: assert property (taken && cmd_status_query && !cmd_serial_poll
		|=> resp_valid && resp_data == $past(summary_status_byte)) else $error("Status query answer wrong.");
	mask_answer_a: assert property (taken && cmd_mask_query && !cmd_serial_poll && !cmd_status_query
		|=> resp_valid && resp_data == $past(service_request_mask)) else $error("Mask query answer wrong.");
	trigger_fire_a: assert property (fire_ok |=> trigger_fire &&
		applied_volt_level == $past(trig_volt_level) && waiting_for_trigger == $past(continuous_arm))
		else $error("Qualified trigger did not fire correctly.");
	trigger_gate_a: assert property (trigger_fire |-> $past(fire_ok))
		else $error("Trigger fired without every gate open.");
	wait_hold_a: assert property (taken && cmd_wait |=> !cmd_ready)
		else $error("Wait command did not hold off commands.");
endmodule

bind status_trigger_core status_trigger_checker #(.LEVEL_W(LEVEL_W)) i_status_trigger_checker (.*);

// ### verification/status_trigger_common_cmds_tb_top.sv
// Bench for the status and trigger core: command strobes with expected answers.
// Assumes the package, core, checker bind and subtest engine model compile first.
`timescale 1ns/100ps
module status_trigger_common_cmds_tb_top;
	import status_trigger_pkg::*;
	localparam int SW = 0, SQ = 1, ST = 2, TG = 3, GT = 4, IA = 5, AB = 6, TQ = 7, DQ = 8, WT = 9;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_serial_poll = 1'b0;
	logic continuous_arm = 1'b0;
	logic listen_addressed = 1'b1;
	logic output_on = 1'b1;
	logic ops_pending = 1'b0;
	logic [9:0] cmd_sel = 10'h000;
	logic [7:0] cmd_mask_data = 8'h00;
	logic [7:0] src = 8'h00;
	logic [7:0] fail_map = 8'h00;
	logic [3:0] delay = 4'h1;
	logic [15:0] trig_volt_level = 16'h1234;
	logic [15:0] trig_curr_level = 16'h0abc;
	trig_src_e trigger_source = TRIG_SRC_BUS;
	logic [7:0] st_map [4] = '{8'hff, 8'hff, 8'h12, 8'h00};
	logic [7:0] st_exp [4] = '{8'h17, 8'hf7, 8'h12, 8'h00};
	logic cmd_ready, resp_valid, service_request, waiting_for_trigger, trigger_fire, subtest_done, subtest_fail;
	logic [7:0] resp_data, service_request_mask, summary_status_byte, subtest_start;
	logic [15:0] applied_volt_level, applied_curr_level;
	int fails = 0;
	int tests_run = 0;
	// Fire in bit 8 and the waiting flag in bit 0, so one compare covers both.
	wire [15:0] trg_st = {7'h00, trigger_fire, 7'h00, waiting_for_trigger};

	// Clock of 4 ns.
	always #2 sys_clk = ~sys_clk;

	status_trigger_core #(.LEVEL_W(16)) i_status_trigger_core (.sys_clk, .resetn, .cmd_valid, .cmd_ready,
		.cmd_mask_write(cmd_sel[SW]), .cmd_mask_data, .cmd_mask_query(cmd_sel[SQ]), .cmd_status_query(cmd_sel[ST]),
		.cmd_serial_poll, .cmd_trigger(cmd_sel[TG]), .cmd_group_trigger(cmd_sel[GT]), .cmd_init_arm(cmd_sel[IA]),
		.cmd_abort(cmd_sel[AB]), .cmd_tst_query(cmd_sel[TQ]), .cmd_diag_query(cmd_sel[DQ]), .cmd_wait(cmd_sel[WT]),
		.continuous_arm, .trigger_source, .listen_addressed, .output_on, .trig_volt_level, .trig_curr_level,
		.operation_summary(src[7]), .event_summary(src[5]), .output_queue_count_nonzero(src[4]),
		.questionable_summary(src[3]), .error_queue_nonempty(src[2]), .sequence_running(src[1]), .busy(src[0]),
		.ops_pending, .resp_valid, .resp_data, .service_request, .service_request_mask, .summary_status_byte,
		.waiting_for_trigger, .trigger_fire, .applied_volt_level, .applied_curr_level, .subtest_start,
		.subtest_done, .subtest_fail);
	subtest_engine_model i_subtest_engine_model (.sys_clk, .subtest_start, .fail_map, .delay, .subtest_done,
		.subtest_fail);

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Waits for ready, holds one command for one edge, returns just after the taking edge.
	task automatic issue(input int idx, input logic [7:0] data);
		for (int n = 0; n < 500 && cmd_ready !== 1'b1; n++) begin
			@(posedge sys_clk);
			#1;
		end
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_sel <= 10'h001 << idx;
		cmd_mask_data <= data;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_sel <= 10'h000;
		#1;
	endtask
	// The answer stands for one cycle only, so it is compared right after the taking edge.
	task automatic query(input int idx, input logic [7:0] exp);
		issue(idx, 8'h00);
		chk($sformatf("answer %0d", idx), {7'h00, 1'b1, exp}, {7'h00, resp_valid, resp_data});
	endtask
	task automatic poll(input logic [7:0] exp);
		@(posedge sys_clk);
		cmd_serial_poll <= 1'b1;
		@(posedge sys_clk);
		cmd_serial_poll <= 1'b0;
		#1;
		chk("poll", {7'h00, 1'b1, exp}, {7'h00, resp_valid, resp_data});
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence: status, trigger, self test, then wait-to-continue.
	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		#1;
		chk("mask reset", 16'h0000, {8'h00, service_request_mask});
		issue(SW, 8'hff);
		query(SQ, 8'hbf);
		src <= 8'h80;
		query(ST, 8'hc0);
		query(ST, 8'hc0);
		poll(8'hc0);
		poll(8'h80);
		query(ST, 8'hc0);
		issue(SW, 8'h10);
		src <= 8'h9f;
		query(ST, 8'hdf);
		src <= 8'h8f;
		query(ST, 8'h8f);
		$display("test status done");
		issue(TG, 8'h00);
		chk("unarmed trigger", 16'h0000, trg_st);
		issue(IA, 8'h00);
		chk("armed", 16'h0001, trg_st);
		issue(TG, 8'h00);
		chk("fire", 16'h0100, trg_st);
		chk("volt level", 16'h1234, applied_volt_level);
		chk("curr level", 16'h0abc, applied_curr_level);
		issue(TG, 8'h00);
		chk("single arm", 16'h0000, trg_st);
		for (int k = 0; k < 3; k++) begin
			output_on <= (k != 0);
			listen_addressed <= (k != 1);
			trigger_source <= (k == 2) ? TRIG_SRC_EXT : TRIG_SRC_BUS;
			issue(IA, 8'h00);
			issue(k == 1 ? GT : TG, 8'h00);
			chk("gated trigger", 16'h0001, trg_st);
		end
		output_on <= 1'b1;
		listen_addressed <= 1'b1;
		trigger_source <= TRIG_SRC_BUS;
		issue(GT, 8'h00);
		chk("group trigger", 16'h0100, trg_st);
		issue(IA, 8'h00);
		issue(AB, 8'h00);
		chk("abort", 16'h0000, trg_st);
		for (int i = 0; i < 2; i++) begin
			continuous_arm <= 1'b1;
			trig_volt_level <= i ? 16'h9abc : 16'h5678;
			issue(TG, 8'h00);
			chk("rearm", 16'h0101, trg_st);
			chk("level", i ? 16'h9abc : 16'h5678, applied_volt_level);
		end
		$display("test trigger done");
		for (int t = 0; t < 4; t++) begin
			fail_map <= st_map[t];
			delay <= t[0] ? 4'h6 : 4'h1;
			issue(t == 1 ? DQ : TQ, 8'h00);
			for (int n = 0; n < 300 && resp_valid !== 1'b1; n++) begin
				@(posedge sys_clk);
				#1;
			end
			chk("self test", {8'h00, st_exp[t]}, {8'h00, resp_data});
		end
		$display("test self test done");
		ops_pending <= 1'b1;
		issue(WT, 8'h00);
		repeat (4) @(posedge sys_clk);
		#1;
		chk("held ready", 16'h0000, {15'h0000, cmd_ready});
		// The busy source must drop as well, or the hold never lets go.
		ops_pending <= 1'b0;
		src <= 8'h00;
		query(SQ, 8'h10);
		$display("test wait done");
		print_verdict();
	end

	// A hang in any handshake ends the run here instead of stalling.
	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		print_verdict();
	end
endmodule

// ### verification/subtest_engine_model.sv
// Model of the subtest engines that answer the core's self-test walker.
// Assumes one-hot start pulses sampled on sys_clk; one subtest at a time.
`timescale 1ns/100ps
module subtest_engine_model (
	// Clock.
	input wire logic sys_clk,
	// Core side, plus failure pattern and answer delay from the bench.
	input wire logic [7:0] subtest_start,
	input wire logic [7:0] fail_map,
	input wire logic [3:0] delay,
	output logic subtest_done,
	output logic subtest_fail
);
	int count = 0;
	logic [7:0] pending = 8'h00;
	initial begin
		subtest_done = 1'b0;
		subtest_fail = 1'b0;
	end
	// Fail toggles outside the done cycle, so a stale level is never mistaken for a result.
	always @(posedge sys_clk) begin
		subtest_done <= 1'b0;
		subtest_fail <= ~subtest_fail;
		if (subtest_start != 8'h00) begin
			pending <= subtest_start;
			count <= int'(delay);
		end else if (count > 0) begin
			count <= count - 1;
			if (count == 1) begin
				subtest_done <= 1'b1;
				subtest_fail <= |(pending & fail_map);
			end
		end
	end
endmodule
